// [rtl/ppt_port.v]
// Functional notes
// - Eight I/O bits, each with own direction, output, capture and enable.
// - Direction at offset 1, read/write; 0 input, 1 output.
// - Offset 0 read gives synced pin for inputs, stored value for outputs.
// - Offset 0 write loads stored output; input and output paths are separate.
// - Offset 4 write sets stored output bits written with one.
// - Offset 5 write clears stored output bits written with one.
// - Set and clear locations store nothing and are write-only.
// - Rising or falling input edge sets its capture bit until software clears.
// - Offset 3 read returns capture bits without changing them.
// - Offset 3 write clears capture bits written with one.
// - Interrupt enable at offset 2, read/write; one lets capture bit interrupt.
// - Each register is one 32-bit word; only low eight bits exist.
// - Input-configured bits release their output driver.
`timescale 1ns/100ps
`default_nettype none
`include "ppt_map.vh"

module ppt_port (
  input wire mclk,
  input wire rst,
  input wire [`PPT_ADDR_WIDTH-1:0] bus_address,
  input wire bus_chipselect,
  input wire bus_read,
  input wire bus_write,
  input wire [`PPT_BUS_WIDTH-1:0] bus_writedata,
  output reg [`PPT_BUS_WIDTH-1:0] bus_readdata,
  output reg bus_readdatavalid,
  input wire [`PPT_IO_WIDTH-1:0] pin_in,
  output reg [`PPT_IO_WIDTH-1:0] pin_out,
  output reg [`PPT_IO_WIDTH-1:0] pin_oe,
  output reg irq
);

localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_ANSWER = 2'b10;

// Register state
reg [`PPT_IO_WIDTH-1:0] direction_q;
reg [`PPT_IO_WIDTH-1:0] direction_d;
reg [`PPT_IO_WIDTH-1:0] out_value_q;
reg [`PPT_IO_WIDTH-1:0] out_value_d;
reg [`PPT_IO_WIDTH-1:0] int_mask_q;
reg [`PPT_IO_WIDTH-1:0] int_mask_d;
reg [`PPT_IO_WIDTH-1:0] capture_q;
reg [`PPT_IO_WIDTH-1:0] capture_d;
reg irq_d;
reg [1:0] state_q;
reg [1:0] state_d;
reg [`PPT_BUS_WIDTH-1:0] read_word_d;

// Bus decode
wire write_strobe;
wire read_strobe;
wire hit_data;
wire hit_direction;
wire hit_mask;
wire hit_capture;
wire hit_set;
wire hit_clear;
wire [`PPT_IO_WIDTH-1:0] write_byte;

// Input side
wire [`PPT_IO_WIDTH-1:0] pin_level;
wire [`PPT_IO_WIDTH-1:0] pin_edge;
wire [`PPT_IO_WIDTH-1:0] data_view;

////////////////////////////////////////////////////////////////////////////////
// Input synchroniser and edge detector
ppt_in_sync #(
  .WIDTH(`PPT_IO_WIDTH)
) u_in_sync (
  .mclk(mclk),
  .rst(rst),
  .pin_async(pin_in),
  .level_q(pin_level),
  .edge_q(pin_edge)
);

////////////////////////////////////////////////////////////////////////////////
// Address decode; host access is through these strobes only
assign write_strobe = bus_chipselect & bus_write;
assign read_strobe = bus_chipselect & bus_read & ~bus_write;
assign hit_data = (bus_address == `PPT_OFS_PIN_DATA);
assign hit_direction = (bus_address == `PPT_OFS_BIT_DIRECTION);
assign hit_mask = (bus_address == `PPT_OFS_INT_ENABLE_MASK);
assign hit_capture = (bus_address == `PPT_OFS_EDGE_CAPTURE);
assign hit_set = (bus_address == `PPT_OFS_OUTPUT_BIT_SET);
assign hit_clear = (bus_address == `PPT_OFS_OUTPUT_BIT_CLEAR);

// Only the low byte is implemented; upper write bits are dropped
assign write_byte = bus_writedata[`PPT_IO_WIDTH-1:0];

////////////////////////////////////////////////////////////////////////////////
// Direction register
always @*
begin
  direction_d = direction_q;
  if (write_strobe && hit_direction)
  begin
    direction_d = write_byte;
  end
end

always @(posedge mclk)
begin
  if (rst)
  begin
    direction_q <= `PPT_RST_BIT_DIRECTION;
  end
  else
  begin
    direction_q <= direction_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Stored output value: whole write, bit set, bit clear
// Set and clear hold nothing of their own, they only steer this register
always @*
begin
  out_value_d = out_value_q;
  if (write_strobe)
  begin
    if (hit_data)
    begin
      out_value_d = write_byte;
    end
    else if (hit_set)
    begin
      out_value_d = out_value_q | write_byte;
    end
    else if (hit_clear)
    begin
      out_value_d = out_value_q & ~write_byte;
    end
  end
end

always @(posedge mclk)
begin
  if (rst)
  begin
    out_value_q <= `PPT_RST_OUTPUT_VALUE;
  end
  else
  begin
    out_value_q <= out_value_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt enable mask
always @*
begin
  int_mask_d = int_mask_q;
  if (write_strobe && hit_mask)
  begin
    int_mask_d = write_byte;
  end
end

always @(posedge mclk)
begin
  if (rst)
  begin
    int_mask_q <= `PPT_RST_INT_ENABLE_MASK;
  end
  else
  begin
    int_mask_q <= int_mask_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Edge capture; a new edge wins over a same-cycle clear so none is lost
// Edges count on every bit, outputs too, since the pin may be overdriven
always @*
begin
  capture_d = capture_q;
  if (write_strobe && hit_capture)
  begin
    capture_d = capture_q & ~write_byte;
  end
  capture_d = capture_d | pin_edge;
end

always @(posedge mclk)
begin
  if (rst)
  begin
    capture_q <= `PPT_RST_EDGE_CAPTURE;
  end
  else
  begin
    capture_q <= capture_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt request, built from next-state values so it tracks capture
always @*
begin
  irq_d = |(capture_d & int_mask_d);
end

always @(posedge mclk)
begin
  if (rst)
  begin
    irq <= 1'b0;
  end
  else
  begin
    irq <= irq_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drivers registered from the next-state values, so they equal the registers
always @(posedge mclk)
begin
  if (rst)
  begin
    pin_out <= `PPT_RST_OUTPUT_VALUE;
    pin_oe <= `PPT_RST_BIT_DIRECTION;
  end
  else
  begin
    pin_out <= out_value_d;
    pin_oe <= direction_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read view of the data location, chosen per bit by direction
genvar gi;
generate
  for (gi = 0; gi < `PPT_IO_WIDTH; gi = gi + 1)
  begin : g_view
    assign data_view[gi] = direction_q[gi] ? out_value_q[gi] : pin_level[gi];
  end
endgenerate

// Read mux; write-only and unmapped locations answer zero
always @*
begin
  read_word_d = `PPT_RST_READ_DATA;
  case (bus_address)
    `PPT_OFS_PIN_DATA:
    begin
      read_word_d = {`PPT_UPPER_ZERO, data_view};
    end
    `PPT_OFS_BIT_DIRECTION:
    begin
      read_word_d = {`PPT_UPPER_ZERO, direction_q};
    end
    `PPT_OFS_INT_ENABLE_MASK:
    begin
      read_word_d = {`PPT_UPPER_ZERO, int_mask_q};
    end
    `PPT_OFS_EDGE_CAPTURE:
    begin
      read_word_d = {`PPT_UPPER_ZERO, capture_q};
    end
    `PPT_OFS_OUTPUT_BIT_SET:
    begin
      read_word_d = `PPT_RST_READ_DATA;
    end
    `PPT_OFS_OUTPUT_BIT_CLEAR:
    begin
      read_word_d = `PPT_RST_READ_DATA;
    end
    default:
    begin
      read_word_d = `PPT_RST_READ_DATA;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// Read answer sequencer: one cycle from strobe to valid data
// Back-to-back reads are accepted; each gets its own answer cycle
always @*
begin
  state_d = state_q;
  case (state_q)
    ST_IDLE:
    begin
      if (read_strobe)
      begin
        state_d = ST_ANSWER;
      end
    end
    ST_ANSWER:
    begin
      if (read_strobe)
      begin
        state_d = ST_ANSWER;
      end
      else
      begin
        state_d = ST_IDLE;
      end
    end
    default:
    begin
      state_d = ST_IDLE;
    end
  endcase
end

always @(posedge mclk)
begin
  if (rst)
  begin
    state_q <= ST_IDLE;
    bus_readdata <= `PPT_RST_READ_DATA;
    bus_readdatavalid <= 1'b0;
  end
  else
  begin
    state_q <= state_d;
    bus_readdatavalid <= (state_d == ST_ANSWER);
    if (read_strobe)
    begin
      bus_readdata <= read_word_d;
    end
    else
    begin
      bus_readdata <= `PPT_RST_READ_DATA;
    end
  end
end

endmodule // ppt_port

`default_nettype wire

// [include/ppt_map.vh]
`ifndef PPT_MAP_VH
`define PPT_MAP_VH

// Port geometry
`define PPT_IO_WIDTH 8
`define PPT_BUS_WIDTH 32
`define PPT_ADDR_WIDTH 3

// Word offsets of the register map
`define PPT_OFS_PIN_DATA 3'h0
`define PPT_OFS_BIT_DIRECTION 3'h1
`define PPT_OFS_INT_ENABLE_MASK 3'h2
`define PPT_OFS_EDGE_CAPTURE 3'h3
`define PPT_OFS_OUTPUT_BIT_SET 3'h4
`define PPT_OFS_OUTPUT_BIT_CLEAR 3'h5

// Reset values
`define PPT_RST_BIT_DIRECTION 8'h00
`define PPT_RST_OUTPUT_VALUE 8'h00
`define PPT_RST_INT_ENABLE_MASK 8'h00
`define PPT_RST_EDGE_CAPTURE 8'h00
`define PPT_RST_READ_DATA 32'h00000000

// Fill for the unimplemented upper bits of every register
`define PPT_UPPER_ZERO 24'h000000

// Read answer timing: read data follows the read strobe by this many cycles
`define PPT_READ_LATENCY_CYC 1

`endif

// [rtl/ppt_in_sync.v]
`timescale 1ns/100ps
`default_nettype none

module ppt_in_sync #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] pin_async,
  output reg [WIDTH-1:0] level_q,
  output reg [WIDTH-1:0] edge_q
);

reg [WIDTH-1:0] stage1_q;
reg [WIDTH-1:0] stage2_q;
reg [WIDTH-1:0] stage3_q;
reg primed_q;
wire [WIDTH-1:0] agree;
wire [WIDTH-1:0] change;

////////////////////////////////////////////////////////////////////////////////
// First stage feeds only the second stage
// Stages keep sampling through reset so the pin level is flushed in
always @(posedge mclk)
begin
  stage1_q <= pin_async;
  stage2_q <= stage1_q;
  stage3_q <= stage2_q;
end

////////////////////////////////////////////////////////////////////////////////
// A change counts once the later two stages agree
assign agree = ~(stage2_q ^ stage3_q);
assign change = agree & (stage3_q ^ level_q);

// Level tracks the pins during reset, so release shows no false edge
always @(posedge mclk)
begin
  if (rst)
  begin
    level_q <= stage3_q;
    edge_q <= {WIDTH{1'b0}};
    primed_q <= 1'b0;
  end
  else
  begin
    level_q <= (level_q & ~agree) | (stage3_q & agree);
    edge_q <= primed_q ? change : {WIDTH{1'b0}};
    primed_q <= 1'b1;
  end
end

endmodule // ppt_in_sync

`default_nettype wire

// [tb/ppt_port_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module ppt_port_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] bus_address,
  input wire logic bus_chipselect,
  input wire logic bus_read,
  input wire logic bus_write,
  input wire logic [31:0] bus_writedata,
  input wire logic [31:0] bus_readdata,
  input wire logic bus_readdatavalid,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire rd = bus_chipselect && bus_read && !bus_write;
  wire wr = bus_chipselect && bus_write;
  wire [7:0] wd = bus_writedata[7:0];
  ////////////////////////////////////////////////////////////
  property p_rd; rd |=> bus_readdatavalid && bus_readdata[31:8] == 24'h000000; endproperty
  a_rd: assert property (p_rd)
    else $error("read answer missing or upper bits set");
  property p_nord; !rd |=> !bus_readdatavalid; endproperty
  a_nord: assert property (p_nord)
    else $error("read answer without request");
  property p_dir; wr && bus_address == 3'h1 |=> pin_oe == $past(wd); endproperty
  a_dir: assert property (p_dir)
    else $error("driver enable not loaded from direction");
  property p_rdir; rd && bus_address == 3'h1 |=> bus_readdata[7:0] == pin_oe; endproperty
  a_rdir: assert property (p_rdir)
    else $error("direction read back wrong");
  property p_out; wr && bus_address == 3'h0 |=> pin_out == $past(wd); endproperty
  a_out: assert property (p_out)
    else $error("output value not loaded");
  property p_set; wr && bus_address == 3'h4 |=> pin_out == ($past(pin_out) | $past(wd)); endproperty
  a_set: assert property (p_set)
    else $error("bit set wrong");
  property p_clr; wr && bus_address == 3'h5 |=> pin_out == ($past(pin_out) & ~$past(wd)); endproperty
  a_clr: assert property (p_clr)
    else $error("bit clear wrong");
  property p_hold; !wr |=> $stable(pin_out) && $stable(pin_oe); endproperty
  a_hold: assert property (p_hold)
    else $error("outputs changed without a write");
  property p_wo; rd && bus_address >= 3'h4 |=> bus_readdata == 32'h00000000; endproperty
  a_wo: assert property (p_wo)
    else $error("write-only place read nonzero");
  property p_mask; wr && bus_address == 3'h2 && wd == 8'h00 |=> !irq; endproperty
  a_mask: assert property (p_mask)
    else $error("interrupt with all enables off");
  c_read: cover property (rd ##1 bus_readdatavalid);
  c_irq: cover property ($rose(irq));
  c_set: cover property (wr && bus_address == 3'h4);
endmodule // ppt_port_asserts
bind ppt_port ppt_port_asserts ppt_port_asserts_inst (.mclk(mclk), .rst(rst),
  .bus_address(bus_address), .bus_chipselect(bus_chipselect), .bus_read(bus_read),
  .bus_write(bus_write), .bus_writedata(bus_writedata), .bus_readdata(bus_readdata),
  .bus_readdatavalid(bus_readdatavalid), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .irq(irq));
`default_nettype wire

// [tb/ppt_pin_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Board logic on the pins; it always drives, so released bits never float
module ppt_pin_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_level
);
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // ppt_pin_model
`default_nettype wire

// [tb/ppt_port_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module ppt_port_tb_top;
  logic mclk = 0, rst = 1, cs = 0, rd = 0, wr = 0;
  logic [2:0] adr = 3'h0;
  logic [31:0] wd = 32'h00000000;
  logic [7:0] ext = 8'h00, outv, r;
  wire [31:0] rdata;
  wire [7:0] pout, poe, plev;
  wire rdv, irq;
  int num_errors = 0, tests_run = 0, i;
  integer seed = 32'hFA2B848B;
  logic [31:0] expq[$];
  always #2.5 mclk = ~mclk;
  ppt_port ppt_port_inst (.mclk(mclk), .rst(rst), .bus_address(adr), .bus_chipselect(cs),
    .bus_read(rd), .bus_write(wr), .bus_writedata(wd), .bus_readdata(rdata),
    .bus_readdatavalid(rdv), .pin_in(plev), .pin_out(pout), .pin_oe(poe), .irq(irq));
  ppt_pin_model ppt_pin_model_inst (.pin_out(pout), .pin_oe(poe), .ext_level(ext),
    .pin_level(plev));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // Random upper bits: the port must ignore them
  task wreg(input logic [2:0] a, input logic [7:0] d);
    cs = 1; wr = 1; adr = a; wd = ({$random(seed)} & 32'hFFFFFF00) | d;
    @(posedge mclk); #1 cs = 0; wr = 0;
    @(posedge mclk); #1;
  endtask
  task rreg(input logic [2:0] a, input logic [7:0] e);
    expq.push_back({24'h000000, e});
    cs = 1; rd = 1; adr = a;
    @(posedge mclk); #1 cs = 0; rd = 0;
    @(posedge mclk); #1;
  endtask
  task settle;
    repeat (8) @(posedge mclk);
    #1;
  endtask
  task summarize;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Old values at the edge are the answer that stood during the cycle
  always @(posedge mclk)
    if (rdv === 1'b1)
      chk("read data", expq.size() ? expq.pop_front() : 32'hFFFFFFFF, rdata);
  initial
  begin
    #5000;
    num_errors++;
    summarize;
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge mclk);
    #1 rst = 0;
    for (i = 0; i < 8; i++) rreg(i[2:0], 8'h00);
    r = $random(seed);
    wreg(3'h1, r); rreg(3'h1, r);
    wreg(3'h2, 8'hA5); rreg(3'h2, 8'hA5);
    wreg(3'h1, 8'hFF);
    outv = $random(seed);
    wreg(3'h0, outv); rreg(3'h0, outv);
    repeat (4)
    begin
      r = $random(seed); wreg(3'h4, r); outv = outv | r; rreg(3'h0, outv);
      r = $random(seed); wreg(3'h5, r); outv = outv & ~r; rreg(3'h0, outv);
    end
    chk("pin_out", {24'h000000, outv}, {24'h000000, pout});
    wreg(3'h1, 8'h0F);
    ext = $random(seed);
    settle;
    rreg(3'h0, {ext[7:4], outv[3:0]});
    chk("pin_oe", 32'h0000000F, {24'h000000, poe});
    wreg(3'h3, 8'hFF); rreg(3'h3, 8'h00);
    wreg(3'h2, 8'h30);
    ext = ~ext;
    settle;
    rreg(3'h3, 8'hF0);
    rreg(3'h3, 8'hF0);
    chk("irq", 32'h1, {31'h0, irq});
    wreg(3'h3, 8'h30); rreg(3'h3, 8'hC0);
    chk("irq", 32'h0, {31'h0, irq});
    wreg(3'h2, 8'hC0);
    chk("irq", 32'h1, {31'h0, irq});
    wreg(3'h2, 8'h00);
    chk("irq", 32'h0, {31'h0, irq});
    // Second toggle gives every input bit the opposite edge
    wreg(3'h3, 8'hFF);
    ext = ~ext;
    settle;
    rreg(3'h3, 8'hF0);
    // Mid-run reset with inputs at non-zero levels; no edge may follow it
    rst = 1;
    repeat (8) @(posedge mclk);
    #1 rst = 0;
    rreg(3'h3, 8'h00);
    rreg(3'h0, ext);
    chk("pin_oe", 32'h0, {24'h000000, poe});
    chk("irq", 32'h0, {31'h0, irq});
    chk("pending reads", 32'h0, expq.size());
    summarize;
  end
endmodule // ppt_port_tb_top
`default_nettype wire
